// [common/dac_map_pkg.sv]
// constants used by the dac register map, not by its link port
package dac_map_pkg;

  // word and address widths of the map
  localparam int DATA_W = 16;
  localparam int ADDR_W = 5;

  // implemented locations
  localparam logic [4:0] ADDR_CODE_CH0 = 5'h00;
  localparam logic [4:0] ADDR_CODE_CH1 = 5'h01;
  localparam logic [4:0] ADDR_REF = 5'h08;
  localparam logic [4:0] ADDR_SHUT = 5'h09;
  localparam logic [4:0] ADDR_GAIN = 5'h0a;
  localparam logic [4:0] ADDR_LOCK = 5'h0b;

  // power-on defaults of the control words
  localparam logic [15:0] RST_REF = 16'h0000;
  localparam logic [15:0] RST_SHUT = 16'h0000;
  localparam logic [15:0] RST_GAIN = 16'h0080;
  localparam logic [15:0] RST_LOCK = 16'h0000;

  // mid-scale output codes per resolution
  localparam logic [15:0] MID_8 = 16'h007f;
  localparam logic [15:0] MID_10 = 16'h01ff;
  localparam logic [15:0] MID_12 = 16'h07ff;

  // full-width ones per resolution, also the reserved read word
  localparam logic [15:0] ONES_8 = 16'h00ff;
  localparam logic [15:0] ONES_10 = 16'h03ff;
  localparam logic [15:0] ONES_12 = 16'h0fff;

  // implemented bits of the control words, single and dual builds
  localparam logic [15:0] PAIR_MASK_ONE = 16'h0003;
  localparam logic [15:0] PAIR_MASK_DUAL = 16'h000f;
  localparam logic [15:0] GAIN_MASK_ONE = 16'h0100;
  localparam logic [15:0] GAIN_MASK_DUAL = 16'h0300;
  localparam logic [15:0] LOCK_MASK_ONE = 16'h0001;
  localparam logic [15:0] LOCK_MASK_DUAL = 16'h0003;
  localparam logic [15:0] POR_FLAG_MASK = 16'h0080;
  localparam int GAIN_POS = 8;

  // values forced while the supply is low
  localparam logic [15:0] BOR_CODE = 16'h0000;

endpackage

// [hw/dac_regmap.sv]
// register memory of the dac with its command link
//
// Contract
// - every location is a sixteen-bit word
// - channel codes at 00h and 01h
// - reference select 08h, shutdown control 09h
// - gain and flags 0Ah, lock flags 0Bh
// - all other locations up to 1Fh reserved
// - supply rise loads every default value
// - channel codes reset to mid-scale
// - control words reset zero, gain 0080h
// - unimplemented bits of valid reads zero
// - reserved read or write: error, no ack
// - reserved read returns ones of the code width
// - hv command to missing bits: error
// - reserved read refuses the command byte
// - after error, start returns to idle
// - codes sized by resolution, right-justified
// - reset clears pointer, sets power-on flag
// - brown-out disables, zeroes, forces shutdown
`timescale 1ns/1ns
`default_nettype none

module dac_regmap #(
  parameter int RES_BITS = 12,  // 8, 10 or 12
  parameter int CHANNELS = 2  // 1 or 2
) (
  input wire logic sys_clk,  // register clock
  input wire logic rst_n,  // power-on reset, active low
  input wire logic link_clk,  // serial link clock
  input wire logic supply_drop_reset,  // brown-out level, async
  input wire logic cmd_valid,  // command offered
  input wire logic cmd_write,  // write, or hv enable
  input wire logic cmd_hv,  // high-voltage command
  input wire logic [4:0] cmd_addr,  // location
  input wire logic [15:0] cmd_wdata,  // write word
  input wire logic cmd_start,  // start condition seen
  output logic cmd_done,  // answer pulse, link clock
  output logic cmd_ack,  // command acknowledged
  output logic cmd_error,  // command error
  output logic [15:0] cmd_rdata,  // read word
  output logic cmd_busy,  // commands refused
  output logic [15:0] output_code_ch0,  // channel zero code
  output logic [15:0] output_code_ch1,  // channel one code
  output logic [3:0] reference_select_bits,  // two bits a channel
  output logic [3:0] shutdown_select_bits,  // two bits a channel
  output logic [1:0] amplifier_gain_bit,  // one bit a channel
  output logic por_flag,  // power-on status
  output logic link_enabled,  // serial interface enabled
  output logic [4:0] addr_pointer  // last addressed location
);

  // ****************************************************************
  // build-dependent masks and defaults
  // ****************************************************************
  localparam logic [15:0] CODE_MASK = (RES_BITS == 8) ?
    dac_map_pkg::ONES_8 : (RES_BITS == 10) ?
    dac_map_pkg::ONES_10 : dac_map_pkg::ONES_12;
  localparam logic [15:0] CODE_MID = (RES_BITS == 8) ?
    dac_map_pkg::MID_8 : (RES_BITS == 10) ?
    dac_map_pkg::MID_10 : dac_map_pkg::MID_12;
  localparam logic [15:0] PAIR_MASK = (CHANNELS == 2) ?
    dac_map_pkg::PAIR_MASK_DUAL : dac_map_pkg::PAIR_MASK_ONE;
  localparam logic [15:0] GAIN_MASK = (CHANNELS == 2) ?
    dac_map_pkg::GAIN_MASK_DUAL : dac_map_pkg::GAIN_MASK_ONE;
  localparam logic [15:0] LOCK_MASK = (CHANNELS == 2) ?
    dac_map_pkg::LOCK_MASK_DUAL : dac_map_pkg::LOCK_MASK_ONE;
  localparam logic [4:0] CH_LIMIT = 5'(CHANNELS);

  // ****************************************************************
  // storage and crossing signals
  // ****************************************************************
  logic [15:0] code [2];  // channel output codes
  logic [15:0] next_code [2];  // next codes
  logic [15:0] ref_reg, next_ref;  // reference select word
  logic [15:0] shut_reg, next_shut;  // shutdown word
  logic [15:0] gain_reg, next_gain;  // gain and power-on flag
  logic [15:0] lock_reg, next_lock;  // lock flags
  logic [4:0] pointer, next_pointer;  // address pointer
  logic enabled, next_enabled;  // interface enable
  logic req_prev, next_req_prev;  // last request toggle seen
  logic bor_prev, next_bor_prev;  // last brown-out level
  logic ans_tgl, next_ans_tgl;  // answer toggle
  logic ans_ack, next_ans_ack;  // answer acknowledge
  logic ans_error, next_ans_error;  // answer error
  logic [15:0] ans_rdata, next_ans_rdata;  // answer word
  logic req_seen;  // synchronised request toggle
  logic bor;  // synchronised brown-out level
  logic req_tgl, req_write, req_hv;  // link captures
  logic [4:0] req_addr;  // link location
  logic [15:0] req_wdata;  // link word
  logic req_event;  // one request to serve
  logic addr_ok;  // location implemented
  logic is_code;  // location is a channel code
  logic [15:0] rd_word;  // stored word at location
  logic [15:0] rd_mask;  // implemented bits at location

  // ****************************************************************
  // link side and crossings
  // ****************************************************************
  link_port u_link (
    .link_clk(link_clk),
    .rst_n(rst_n),
    .cmd_valid(cmd_valid),
    .cmd_write(cmd_write),
    .cmd_hv(cmd_hv),
    .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata),
    .cmd_start(cmd_start),
    .ans_tgl(ans_tgl),
    .ans_ack(ans_ack),
    .ans_error(ans_error),
    .ans_rdata(ans_rdata),
    .req_tgl(req_tgl),
    .req_write(req_write),
    .req_hv(req_hv),
    .req_addr(req_addr),
    .req_wdata(req_wdata),
    .cmd_done(cmd_done),
    .cmd_ack(cmd_ack),
    .cmd_error(cmd_error),
    .cmd_rdata(cmd_rdata),
    .cmd_busy(cmd_busy)
  );

  // request toggle from the link clock
  sync3 #(.INIT(1'b0)) u_req_sync (
    .clk(sys_clk),
    .rst_n(rst_n),
    .d(req_tgl),
    .q(req_seen)
  );

  // brown-out level from the supply monitor
  sync3 #(.INIT(1'b0)) u_bor_sync (
    .clk(sys_clk),
    .rst_n(rst_n),
    .d(supply_drop_reset),
    .q(bor)
  );

  assign req_event = (req_seen != req_prev);

  // ****************************************************************
  // location decode
  // ****************************************************************

  // stored word and implemented bits of the addressed location
  always_comb begin
    rd_word = '0;
    rd_mask = '0;
    addr_ok = 1'b1;
    is_code = 1'b0;
    case (req_addr)
      dac_map_pkg::ADDR_CODE_CH0: begin
        rd_word = code[0];
        rd_mask = CODE_MASK;
        is_code = 1'b1;
      end
      dac_map_pkg::ADDR_CODE_CH1: begin
        rd_word = code[1];
        rd_mask = CODE_MASK;
        is_code = 1'b1;
        addr_ok = (CHANNELS == 2);
      end
      dac_map_pkg::ADDR_REF: begin
        rd_word = ref_reg;
        rd_mask = PAIR_MASK;
      end
      dac_map_pkg::ADDR_SHUT: begin
        rd_word = shut_reg;
        rd_mask = PAIR_MASK;
      end
      dac_map_pkg::ADDR_GAIN: begin
        rd_word = gain_reg;
        rd_mask = GAIN_MASK | dac_map_pkg::POR_FLAG_MASK;
      end
      dac_map_pkg::ADDR_LOCK: begin
        rd_word = lock_reg;
        rd_mask = LOCK_MASK;
      end
      default: addr_ok = 1'b0;  // reserved up to 1fh
    endcase
  end

  // ****************************************************************
  // register file
  // ****************************************************************

  // supply events first, then one served request
  always_comb begin
    next_code = code;
    next_ref = ref_reg;
    next_shut = shut_reg;
    next_gain = gain_reg;
    next_lock = lock_reg;
    next_pointer = pointer;
    next_enabled = enabled;
    next_req_prev = req_seen;
    next_bor_prev = bor;
    next_ans_tgl = ans_tgl;
    next_ans_ack = ans_ack;
    next_ans_error = ans_error;
    next_ans_rdata = ans_rdata;
    if (bor) begin
      // supply low: outputs parked, link shut off
      for (int i = 0; i < 2; i++) begin
        next_code[i] = dac_map_pkg::BOR_CODE;
      end
      next_shut = PAIR_MASK;  // every pair at 11
      next_ref = '0;
      next_gain = gain_reg & ~GAIN_MASK;
      next_enabled = 1'b0;
    end else if (bor_prev) begin
      // supply back above the trip point: factory defaults
      for (int i = 0; i < 2; i++) begin
        next_code[i] = CODE_MID;
      end
      next_ref = dac_map_pkg::RST_REF;
      next_shut = dac_map_pkg::RST_SHUT;
      next_gain = dac_map_pkg::RST_GAIN;
      next_lock = dac_map_pkg::RST_LOCK;
      next_pointer = '0;
      next_enabled = 1'b1;
    end
    if (req_event) begin
      // every request is answered; a disabled link refuses it
      next_ans_tgl = ~ans_tgl;
      next_ans_ack = 1'b0;
      next_ans_error = 1'b0;
      next_ans_rdata = CODE_MASK;
      if (!bor && !bor_prev && enabled) begin
        next_pointer = req_addr;
        if (req_hv) begin
          // lock enable or disable of one channel
          if (req_addr < CH_LIMIT) begin
            next_lock[req_addr[0]] = req_write;
            next_ans_ack = 1'b1;
          end else begin
            next_ans_error = 1'b1;
          end
        end else if (!addr_ok) begin
          next_ans_error = 1'b1;
          next_ans_rdata = CODE_MASK;  // ones of the code width
        end else if (req_write && is_code && lock_reg[req_addr[0]]) begin
          next_ans_error = 1'b1;
        end else if (req_write) begin
          // only implemented bits take data
          next_ans_ack = 1'b1;
          case (req_addr)
            dac_map_pkg::ADDR_CODE_CH0,
            dac_map_pkg::ADDR_CODE_CH1: begin
              next_code[req_addr[0]] = req_wdata & CODE_MASK;
            end
            dac_map_pkg::ADDR_REF: next_ref = req_wdata & PAIR_MASK;
            dac_map_pkg::ADDR_SHUT: next_shut = req_wdata & PAIR_MASK;
            dac_map_pkg::ADDR_GAIN: begin
              next_gain = (req_wdata & GAIN_MASK) |
                (gain_reg & dac_map_pkg::POR_FLAG_MASK);
            end
            default: next_ans_ack = 1'b1;  // lock word is read-only
          endcase
        end else begin
          next_ans_ack = 1'b1;
          next_ans_rdata = rd_word & rd_mask;
        end
      end
    end
  end

  // register the file; reset is the power-on load
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      code[0] <= CODE_MID;
      code[1] <= CODE_MID;
      ref_reg <= dac_map_pkg::RST_REF;
      shut_reg <= dac_map_pkg::RST_SHUT;
      gain_reg <= dac_map_pkg::RST_GAIN;  // flag set
      lock_reg <= dac_map_pkg::RST_LOCK;
      pointer <= '0;
      enabled <= 1'b1;
      req_prev <= 1'b0;
      bor_prev <= 1'b0;
      ans_tgl <= 1'b0;
      ans_ack <= 1'b0;
      ans_error <= 1'b0;
      ans_rdata <= '0;
    end else begin
      code <= next_code;
      ref_reg <= next_ref;
      shut_reg <= next_shut;
      gain_reg <= next_gain;
      lock_reg <= next_lock;
      pointer <= next_pointer;
      enabled <= next_enabled;
      req_prev <= next_req_prev;
      bor_prev <= next_bor_prev;
      ans_tgl <= next_ans_tgl;
      ans_ack <= next_ans_ack;
      ans_error <= next_ans_error;
      ans_rdata <= next_ans_rdata;
    end
  end

  // ****************************************************************
  // outputs, each a register slice
  // ****************************************************************
  assign output_code_ch0 = code[0];
  assign output_code_ch1 = code[1];
  assign reference_select_bits = ref_reg[3:0];
  assign shutdown_select_bits = shut_reg[3:0];
  assign amplifier_gain_bit = gain_reg[dac_map_pkg::GAIN_POS +: 2];
  assign por_flag = gain_reg[7];
  assign link_enabled = enabled;
  assign addr_pointer = pointer;

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence s_live_req;
    req_event && !bor && !bor_prev && enabled;
  endsequence

  sequence s_resv_req;
    s_live_req ##0 (!req_hv && !addr_ok);
  endsequence

  a_resv_refuse: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_resv_req |=> ans_error && !ans_ack && (ans_rdata == CODE_MASK))
    else $error("reserved access not refused");

  a_valid_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_live_req ##0 (!req_hv && !req_write && addr_ok) |=>
      ans_ack && !ans_error && ((ans_rdata & ~$past(rd_mask)) == '0))
    else $error("valid read bad");

  a_code_width: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ((code[0] | code[1]) & ~CODE_MASK) == '0)
    else $error("code exceeds resolution");

  a_bor_force: assert property (@(posedge sys_clk) disable iff (!rst_n)
    bor |=> (code[0] == '0) && (shut_reg == PAIR_MASK) && !enabled
      && (ref_reg == '0))
    else $error("brown-out not forced");

  a_por_load: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (bor_prev && !bor) |=> (code[1] == CODE_MID) && (pointer == '0)
      && (gain_reg == dac_map_pkg::RST_GAIN) && (shut_reg == '0))
    else $error("defaults not loaded");

  a_hv_unimpl: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_live_req ##0 (req_hv && req_addr >= CH_LIMIT) |=> ans_error)
    else $error("hv to missing bits accepted");

  a_ref_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_live_req ##0 (req_write && !req_hv &&
      req_addr == dac_map_pkg::ADDR_REF) |=>
      ref_reg == ($past(req_wdata) & PAIR_MASK))
    else $error("reference write lost");

  a_answer_once: assert property (@(posedge sys_clk) disable iff (!rst_n)
    req_event |=> (ans_tgl != $past(ans_tgl)) ##1 (ans_tgl == $past(ans_tgl)))
    else $error("answer toggle wrong");

endmodule  // dac_regmap

`default_nettype wire

// [hw/link_port.sv]
// link-clock side of the command handshake
`timescale 1ns/1ns
`default_nettype none

module link_port (
  input wire logic link_clk,  // serial link clock
  input wire logic rst_n,  // async reset, active low
  input wire logic cmd_valid,  // command offered
  input wire logic cmd_write,  // write, or hv enable
  input wire logic cmd_hv,  // high-voltage command
  input wire logic [4:0] cmd_addr,  // location
  input wire logic [15:0] cmd_wdata,  // write word
  input wire logic cmd_start,  // start condition seen
  input wire logic ans_tgl,  // answer toggle, system domain
  input wire logic ans_ack,  // answer acknowledge, held
  input wire logic ans_error,  // answer error, held
  input wire logic [15:0] ans_rdata,  // answer word, held
  output logic req_tgl,  // request toggle
  output logic req_write,  // captured write flag
  output logic req_hv,  // captured hv flag
  output logic [4:0] req_addr,  // captured location
  output logic [15:0] req_wdata,  // captured word
  output logic cmd_done,  // answer pulse
  output logic cmd_ack,  // acknowledge of last command
  output logic cmd_error,  // command error, until start
  output logic [15:0] cmd_rdata,  // read word
  output logic cmd_busy  // commands refused
);

  typedef enum logic [1:0] {LK_IDLE, LK_WAIT, LK_ERR} link_state_t;

  link_state_t state, next_state;  // handshake state
  logic ans_seen;  // synchronised answer toggle
  logic next_req_tgl, next_req_write, next_req_hv;  // next captures
  logic [4:0] next_req_addr;  // next location
  logic [15:0] next_req_wdata, next_cmd_rdata;  // next words
  logic next_done, next_ack, next_error, next_busy;  // next answers

  // answer toggle enters this domain through three stages
  sync3 #(.INIT(1'b0)) u_ans_sync (
    .clk(link_clk),
    .rst_n(rst_n),
    .d(ans_tgl),
    .q(ans_seen)
  );

  // capture, wait for the answer, hold errors until a start
  always_comb begin
    next_state = state;
    next_req_tgl = req_tgl;
    next_req_write = req_write;
    next_req_hv = req_hv;
    next_req_addr = req_addr;
    next_req_wdata = req_wdata;
    next_done = 1'b0;
    next_ack = cmd_ack;
    next_error = cmd_error;
    next_cmd_rdata = cmd_rdata;
    next_busy = cmd_busy;
    case (state)
      LK_IDLE: begin
        // fields are held stable until the answer returns
        if (cmd_valid) begin
          next_req_write = cmd_write;
          next_req_hv = cmd_hv;
          next_req_addr = cmd_addr;
          next_req_wdata = cmd_wdata;
          next_req_tgl = ~req_tgl;
          next_busy = 1'b1;
          next_state = LK_WAIT;
        end
      end
      LK_WAIT: begin
        // answer words were stable before the toggle arrived
        if (ans_seen == req_tgl) begin
          next_done = 1'b1;
          next_ack = ans_ack;
          next_error = ans_error;
          next_cmd_rdata = ans_rdata;
          next_busy = ans_error;
          next_state = ans_error ? LK_ERR : LK_IDLE;
        end
      end
      LK_ERR: begin
        // only a new start returns to idle
        if (cmd_start) begin
          next_error = 1'b0;
          next_busy = 1'b0;
          next_state = LK_IDLE;
        end
      end
      default: next_state = LK_IDLE;
    endcase
  end

  // register the handshake
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= LK_IDLE;
      req_tgl <= 1'b0;
      req_write <= 1'b0;
      req_hv <= 1'b0;
      req_addr <= '0;
      req_wdata <= '0;
      cmd_done <= 1'b0;
      cmd_ack <= 1'b0;
      cmd_error <= 1'b0;
      cmd_rdata <= '0;
      cmd_busy <= 1'b0;
    end else begin
      state <= next_state;
      req_tgl <= next_req_tgl;
      req_write <= next_req_write;
      req_hv <= next_req_hv;
      req_addr <= next_req_addr;
      req_wdata <= next_req_wdata;
      cmd_done <= next_done;
      cmd_ack <= next_ack;
      cmd_error <= next_error;
      cmd_rdata <= next_cmd_rdata;
      cmd_busy <= next_busy;
    end
  end

  // error holds until start, then idle follows
  a_error_hold: assert property (@(posedge link_clk) disable iff (!rst_n)
    (state == LK_ERR) |=> (state == (($past(cmd_start)) ? LK_IDLE : LK_ERR)))
    else $error("error state left without start");

endmodule  // link_port

`default_nettype wire

// [hw/sync3.sv]
// three-stage level synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none

module sync3 #(
  parameter logic INIT = 1'b0  // value held under reset
) (
  input wire logic clk,  // destination clock
  input wire logic rst_n,  // async reset, active low
  input wire logic d,  // level from another domain
  output logic q  // filtered level
);

  logic [2:0] stage;  // stage[0] is read only by stage[1]
  logic [2:0] next_stage;  // shifted chain
  logic next_q;  // next filtered level

  // shift the chain; accept a change once the last two agree
  always_comb begin
    next_stage = {stage[1:0], d};
    next_q = (stage[1] == stage[2]) ? stage[2] : q;
  end

  // register the chain and the filtered level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage <= {3{INIT}};
      q <= INIT;
    end else begin
      stage <= next_stage;
      q <= next_q;
    end
  end

endmodule  // sync3

`default_nettype wire

// [tb/link_master.sv]
// bus master model that frames one link command at a time
`timescale 1ns/1ns
`default_nettype none

// ******************************
// serial master and its clock
// ******************************
module link_master (
  input wire logic cmd_done,  // answer pulse
  input wire logic cmd_ack,  // acknowledge
  input wire logic cmd_error,  // command error
  input wire logic [15:0] cmd_rdata,  // read word
  output logic link_clk,  // gated serial clock
  output logic cmd_valid,  // command offered
  output logic cmd_write,  // write or enable
  output logic cmd_hv,  // high-voltage command
  output logic [4:0] cmd_addr,  // location
  output logic [15:0] cmd_wdata,  // write word
  output logic cmd_start  // start condition
);
  logic ph = 1'b0;  // free phase, 30 ns period
  logic run = 1'b0;  // clock stands still between frames
  // phase offset keeps it unrelated to the system clock
  initial begin
    #7;
    forever #15 ph = ~ph;
  end
  assign link_clk = ph & run;
  // idle levels at time zero
  initial begin
    {cmd_valid, cmd_write, cmd_hv, cmd_start} = '0;
    {cmd_addr, cmd_wdata} = '0;
  end
  // hold the request until the answer pulse, then release it
  task automatic xfer(input logic w, h, input logic [4:0] a,
    input logic [15:0] d, output logic ak, er, output logic [15:0] rd,
    output bit ok);
    ok = 0;
    @(negedge ph) run = 1;
    repeat (2) @(negedge ph);
    {cmd_valid, cmd_write, cmd_hv, cmd_addr, cmd_wdata} = {1'b1, w, h, a, d};
    for (int i = 0; i < 200 && !ok; i++) begin
      @(posedge ph) #1;
      ok = (cmd_done === 1'b1);
    end
    {ak, er, rd} = {cmd_ack, cmd_error, cmd_rdata};
    // released lines show the inverse of the last value
    @(negedge ph) {cmd_valid, cmd_addr, cmd_wdata} = {1'b0, ~a, ~d};
    if (er === 1'b1) begin
      cmd_start = 1;
      @(negedge ph) cmd_start = 0;
    end
    repeat (3) @(negedge ph);
    run = 0;
  endtask
endmodule  // link_master

`default_nettype wire

// [tb/test_dac_regmap.sv]
// self-checking bench of the dac register map
`timescale 1ns/1ns
`default_nettype none

// ******************************
// bench top
// ******************************
module test_dac_regmap;
  logic sys_clk, rst_n, supply_drop_reset, link_clk, cmd_valid, cmd_write;
  logic cmd_hv, cmd_start, cmd_done, cmd_ack, cmd_error, cmd_busy;
  logic por_flag, link_enabled, ak, er;
  logic [4:0] cmd_addr, addr_pointer, a5;
  logic [15:0] cmd_wdata, cmd_rdata, output_code_ch0, output_code_ch1, rd;
  logic [3:0] reference_select_bits, shutdown_select_bits;
  logic [1:0] amplifier_gain_bit;
  logic [15:0] mem [32];  // expected read word per location
  logic [4:0] vl [6] = '{5'h00, 5'h01, 5'h08, 5'h09, 5'h0a, 5'h0b};
  bit ok;
  int fails = 0, checks_done = 0, seed = 25;

  dac_regmap u_dut (.sys_clk, .rst_n, .link_clk, .supply_drop_reset,
    .cmd_valid, .cmd_write, .cmd_hv, .cmd_addr, .cmd_wdata, .cmd_start,
    .cmd_done, .cmd_ack, .cmd_error, .cmd_rdata, .cmd_busy,
    .output_code_ch0, .output_code_ch1, .reference_select_bits,
    .shutdown_select_bits, .amplifier_gain_bit, .por_flag, .link_enabled,
    .addr_pointer);
  link_master u_link (.cmd_done, .cmd_ack, .cmd_error, .cmd_rdata,
    .link_clk, .cmd_valid, .cmd_write, .cmd_hv, .cmd_addr, .cmd_wdata,
    .cmd_start);

  // system clock, 10 ns
  initial begin
    sys_clk = 0;
    forever #5 sys_clk = ~sys_clk;
  end

  function automatic bit resv(input logic [4:0] a);
    return !(a < 5'h02 || (a >= 5'h08 && a <= 5'h0b));
  endfunction

  task automatic tally_and_finish();
    if (fails == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [23:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  // one command; exp holds ack, error and read word
  task automatic cmd(input logic w, h, input logic [4:0] a,
    input logic [15:0] d, input logic [17:0] exp);
    u_link.xfer(w, h, a, d, ak, er, rd, ok);
    if (!ok) begin
      fails++;
      tally_and_finish();
    end
    check("answer", {6'h0, exp}, {6'h0, ak, er, w ? exp[15:0] : rd});
    check("idle", 24'h0, {22'h0, cmd_busy, cmd_error});
  endtask

  task automatic rdw(input logic [4:0] a);
    cmd(0, 0, a, 16'h0, resv(a) ? {2'b01, 16'h0fff} : {2'b10, mem[a]});
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    cmd(1, 0, a, d, {~resv(a), resv(a), 16'h0});
    case (a)
      5'h00, 5'h01: mem[a] = d & 16'h0fff;
      5'h08, 5'h09: mem[a] = d & 16'h000f;
      5'h0a: mem[a] = (d & 16'h0300) | 16'h0080;
      default: ;  // lock word and reserved keep their value
    endcase
  endtask

  task automatic defaults();
    for (int a = 0; a < 32; a++)
      mem[a] = resv(5'(a)) ? 16'h0fff : 16'h0000;
    mem[0] = 16'h07ff;
    mem[1] = 16'h07ff;
    mem[10] = 16'h0080;
  endtask

  // main sequence
  initial begin
    rst_n = 0;
    supply_drop_reset = 0;
    defaults();
    repeat (3) @(negedge sys_clk);
    rst_n = 1;
    repeat (4) @(negedge sys_clk);
    check("pointer", 24'h0, {19'h0, addr_pointer});
    check("por", 24'h1, {23'h0, por_flag});
    for (int a = 0; a < 32; a++)
      rdw(5'(a));
    wr(5'h01, 16'hffff);
    rdw(5'h01);
    for (int i = 0; i < 24; i++) begin
      a5 = i[0] ? 5'($random(seed)) : vl[i % 6];
      wr(a5, 16'($random(seed)));
      rdw(a5);
      if (!resv(a5))
        check("pointer", {19'h0, a5}, {19'h0, addr_pointer});
    end
    check("ports",
      {mem[0][11:0], mem[9][3:0], mem[8][3:0], mem[10][9:8], 2'b0},
      {output_code_ch0[11:0], shutdown_select_bits, reference_select_bits,
      amplifier_gain_bit, 2'b0});
    cmd(1, 1, 5'h00, 16'h0, {2'b10, 16'h0});
    cmd(1, 0, 5'h00, 16'h0123, {2'b01, 16'h0});
    mem[11] = 16'h0001;
    rdw(5'h00);
    rdw(5'h0b);
    cmd(1, 1, 5'h02, 16'h0, {2'b01, 16'h0});
    cmd(0, 1, 5'h00, 16'h0, {2'b10, 16'h0fff});
    mem[11] = 16'h0000;
    rdw(5'h0b);
    @(negedge sys_clk) supply_drop_reset = 1;
    repeat (6) @(negedge sys_clk);
    check("brownout", 24'h000f00,
      {output_code_ch0[11:0], shutdown_select_bits, reference_select_bits,
      amplifier_gain_bit, 1'b0, link_enabled});
    cmd(0, 0, 5'h00, 16'h0, {2'b00, 16'h0fff});
    @(negedge sys_clk) supply_drop_reset = 0;
    repeat (6) @(negedge sys_clk);
    defaults();
    for (int i = 0; i < 6; i++)
      rdw(vl[i]);
    check("code1", {8'h0, mem[1]}, {8'h0, output_code_ch1});
    tally_and_finish();
  end
endmodule  // test_dac_regmap

`default_nettype wire
